// File: rtl/rx_ctrl_defines.vh
// Constants for the receive-side preamble, timeout and mode controller
// Behaviour
// RQ1: Preamble found only on alternating 0101 pattern
// RQ2: Size select 00/01/10 gives 1/2/3 bytes
// RQ3: Host sets tolerance ten with two bytes
// RQ4: Pulse preamble flag per detection when enabled
// RQ5: Calibrate low band at 434 MHz after reset
// RQ6: Flag temperature shift beyond selected delta
// RQ7: Auto calibration on shift when enabled
// RQ8: Host trigger starts calibration in standby
// RQ9: One calibration run lasts about 10 ms
// RQ10: Host selects FSK/OOK before requesting calibration
// RQ11: Separate temperature and flag per band
// RQ12: Temperature values hidden during sleep mode
// RQ13: Signal-level timeout after limit times 16 bits
// RQ14: Preamble timeout after limit times 16 bits
// RQ15: Sync timeout after limit times 16 bits; code arms it only for trigger select 001 or 110
// RQ16: Trigger select gates signal and preamble timeouts
// RQ17: Mode codes enable sleep, standby, tx, rx
// RQ18: Codes 010/100 enable synthesizer only
// RQ19: Sub-blocks wake in fixed order
// RQ20: Synthesizer ready only after oscillator calibration
// RQ21: FSK tx startup 5us+1.25 ramp+half bit
// RQ22: OOK tx startup 5us plus half bit
// RQ23: Timeout counters run only inside receive mode
`ifndef RX_CTRL_DEFINES_VH
`define RX_CTRL_DEFINES_VH
`define CLK_MHZ            250
`define CAL_TIME_MS        10
`define CAL_CYCLES         (`CAL_TIME_MS * 1000 * `CLK_MHZ)
`define TX_BASE_US         5
`define TX_BASE_CYCLES     (`TX_BASE_US * `CLK_MHZ)
`define OSC_CAL_CYCLES     64
`define WAKE_STEP_CYCLES   16
`define TIMEOUT_BITS_UNIT  16
`define MODE_SLEEP         3'h0
`define MODE_STANDBY       3'h1
`define MODE_SYNTH_TX      3'h2
`define MODE_TX            3'h3
`define MODE_SYNTH_RX      3'h4
`define MODE_RX            3'h5
`define TRIG_RSSI          3'h1
`define TRIG_PREAMBLE      3'h6
`define TRIG_BOTH          3'h7
`endif

// File: rtl/rx_ctrl.v
// Receive-side preamble detector, calibration, timeout and mode controller
`timescale 1ns/10ps
`default_nettype none
`include "rx_ctrl_defines.vh"
module rx_ctrl #(
    parameter CAL_CYCLES = `CAL_CYCLES
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        bit_strobe,              // One pulse per bit period
    input  wire        rx_bit,                  // Demodulated bit at strobe
    input  wire        preamble_detector_enable,
    input  wire [1:0]  preamble_size_sel,
    input  wire [4:0]  preamble_error_tolerance,
    input  wire [2:0]  mode,
    input  wire        ook_mode,                // 1 = OOK, 0 = FSK
    input  wire [7:0]  pa_ramp_time,            // Ramp time in us
    input  wire [15:0] half_bit_cycles,         // Half bit period in cycles
    input  wire        high_band,
    input  wire [7:0]  temperature,             // Sensor reading, degrees
    input  wire [1:0]  temp_delta_select,
    input  wire        temp_watch_disable,
    input  wire        auto_iq_cal_enable,
    input  wire        iq_cal_trigger,          // One-cycle host request
    input  wire [7:0]  signal_level_value,
    input  wire [7:0]  signal_level_threshold,
    input  wire        sync_match_flag,
    input  wire [2:0]  rx_trigger_select,
    input  wire [7:0]  rssi_wait_limit,
    input  wire [7:0]  preamble_wait_limit,
    input  wire [7:0]  sync_wait_limit,
    output reg         preamble_found_flag,     // Pulse per detection
    output reg         timeout_irq,             // Pulse on first timeout per receive entry
    output reg         temp_shift_flag,         // Current band copy
    output reg  [7:0]  stored_temperature,      // Current band copy
    output reg         temp_read_valid,         // Low in sleep
    output reg         cal_busy,
    output reg         regulator_en,
    output reg         osc_en,
    output reg         synth_en,
    output reg         synth_rx_tune,           // Tuned to carrier minus IF
    output reg         tx_en,
    output reg         rx_en,
    output reg         synth_ready,
    output reg         tx_ready
);
    // Preamble detector: count bits matching alternation, tolerate errors
    reg        prev_bit;
    reg [4:0]  err_cnt;
    reg [4:0]  good_cnt;
    // Qualifying length in bits: 8, 16 or 24 for size codes 00/01/10
    wire [4:0] need_bits = {preamble_size_sel + 2'h1, 3'h0};
    wire       size_ok   = (preamble_size_sel != 2'h3);          // [RQ2]
    always @(posedge mclk)
    begin
        if (rst)
        begin
            prev_bit            <= 1'b0;
            err_cnt             <= 5'h00;
            good_cnt            <= 5'h00;
            preamble_found_flag <= 1'b0;
        end
        else
        begin
            preamble_found_flag <= 1'b0;
            if (!preamble_detector_enable || !rx_en)
            begin
                good_cnt <= 5'h00;
                err_cnt  <= 5'h00;
            end
            else if (bit_strobe)
            begin
                prev_bit <= rx_bit;
                if (rx_bit != prev_bit)                          // [RQ1]
                begin
                    if (good_cnt + 5'h01 >= need_bits && size_ok)
                    begin
                        preamble_found_flag <= 1'b1;             // [RQ4]
                        good_cnt <= 5'h00;
                        err_cnt  <= 5'h00;
                    end
                    else
                        good_cnt <= good_cnt + 5'h01;
                end
                else if (err_cnt >= preamble_error_tolerance)
                begin
                    // Too many breaks: restart qualification
                    good_cnt <= 5'h00;
                    err_cnt  <= 5'h00;
                end
                else
                    err_cnt <= err_cnt + 5'h01;
            end
        end
    end

    // Calibration: per-band temperature and flag copies
    reg  [7:0]  band_temp [0:1];                                 // [RQ11]
    reg  [1:0]  band_flag;
    reg         boot_cal;                                        // [RQ5]
    reg         cal_band;   // Band being calibrated
    reg  [31:0] cal_cnt;
    wire [7:0]  cur_temp  = band_temp[high_band];
    wire [7:0]  delta     = (temperature > cur_temp) ?
                            temperature - cur_temp : cur_temp - temperature;
    // Threshold is 5 x (select + 1) degrees, built as 4x plus 1x
    wire [7:0]  limit     = {1'b0, ({3'h0, temp_delta_select} + 5'h01), 2'h0}
                            + {6'h00, temp_delta_select} + 8'h01;
    wire        shift_hit = !temp_watch_disable && (delta > limit); // [RQ6]
    // Boot run, temperature shift with auto on, or standby request
    wire        cal_start = boot_cal ||
                    (shift_hit && auto_iq_cal_enable) ||         // [RQ7]
                    (iq_cal_trigger && mode == `MODE_STANDBY);  // [RQ8]
    always @(posedge mclk)
    begin
        if (rst)
        begin
            band_temp[0] <= 8'h00;
            band_temp[1] <= 8'h00;
            band_flag    <= 2'h0;
            boot_cal     <= 1'b1;
            cal_cnt      <= 32'h0;
            cal_busy     <= 1'b0;
            cal_band     <= 1'b0;
        end
        else if (cal_busy)
        begin
            // Run lasts the calibration time, then stores temperature
            if (cal_cnt == CAL_CYCLES - 1)                       // [RQ9]
            begin
                cal_busy <= 1'b0;
                // Result goes to the band that was chosen at start
                band_temp[cal_band] <= temperature;
                band_flag[cal_band] <= 1'b0;
            end
            cal_cnt <= cal_cnt + 32'h1;
        end
        else
        begin
            if (shift_hit)
                band_flag[high_band] <= 1'b1;
            if (cal_start)
            begin
                // Boot run is low band only, host keeps FSK mode [RQ10]
                boot_cal <= 1'b0;
                cal_busy <= 1'b1;
                cal_band <= boot_cal ? 1'b0 : high_band;         // [RQ5]
                cal_cnt  <= 32'h0;
            end
        end
    end

    // Readback is hidden while sleeping; values are kept
    always @(posedge mclk)
    begin
        if (rst)
        begin
            stored_temperature <= 8'h00;
            temp_shift_flag    <= 1'b0;
            temp_read_valid    <= 1'b0;
        end
        else
        begin
            temp_read_valid <= (mode != `MODE_SLEEP);               // [RQ12]
            stored_temperature <= (mode != `MODE_SLEEP) ? cur_temp : 8'h00;
            temp_shift_flag <= (mode != `MODE_SLEEP) & band_flag[high_band];
        end
    end

    // Timeouts: count 16-bit units from receive entry
    reg  [11:0] unit_cnt;   // Bit-period units of 16 bits
    reg  [3:0]  bit_cnt;
    reg         rssi_seen, pre_seen, sync_seen, to_done;
    wire        in_rx    = (mode == `MODE_RX);
    wire        rssi_on  = (rx_trigger_select == `TRIG_RSSI) ||
                           (rx_trigger_select == `TRIG_BOTH);   // [RQ16]
    wire        pre_on   = (rx_trigger_select == `TRIG_PREAMBLE) ||
                           (rx_trigger_select == `TRIG_BOTH);   // [RQ16]
    wire        sync_on  = (rx_trigger_select == `TRIG_RSSI) ||
                           (rx_trigger_select == `TRIG_PREAMBLE);
    wire [11:0] u        = unit_cnt;
    // A limit of zero keeps that timeout off
    wire        hit_rssi = rssi_on && !rssi_seen && rssi_wait_limit != 8'h00
                           && u == {4'h0, rssi_wait_limit};     // [RQ13]
    wire        hit_pre  = pre_on && !pre_seen && preamble_wait_limit != 8'h00
                           && u == {4'h0, preamble_wait_limit}; // [RQ14]
    wire        hit_sync = sync_on && !sync_seen && sync_wait_limit != 8'h00
                           && u == {4'h0, sync_wait_limit};     // [RQ15]
    always @(posedge mclk)
    begin
        if (rst || !in_rx)
        begin
            // Leaving receive clears everything [RQ23]
            unit_cnt    <= 12'h000;
            bit_cnt     <= 4'h0;
            rssi_seen   <= 1'b0;
            pre_seen    <= 1'b0;
            sync_seen   <= 1'b0;
            to_done     <= 1'b0;
            timeout_irq <= 1'b0;
        end
        else
        begin
            timeout_irq <= 1'b0;
            if (signal_level_value > signal_level_threshold)
                rssi_seen <= 1'b1;                               // [RQ23]
            if (preamble_found_flag)
                pre_seen <= 1'b1;
            if (sync_match_flag)
                sync_seen <= 1'b1;
            if (bit_strobe && unit_cnt != 12'hfff)
            begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == `TIMEOUT_BITS_UNIT - 1)
                    unit_cnt <= unit_cnt + 12'h001;
            end
            if (!to_done && (hit_rssi || hit_pre || hit_sync))
            begin
                timeout_irq <= 1'b1;
                to_done     <= 1'b1;
            end
        end
    end

    // Mode wake sequence: oscillator, synth with cal, then tx or rx
    localparam ST_IDLE  = 4'h1;
    localparam ST_OSC   = 4'h2;
    localparam ST_SYCAL = 4'h4;
    localparam ST_RUN   = 4'h8;
    reg [3:0]  state;
    reg [2:0]  cur_mode;
    reg [31:0] step_cnt;
    wire want_synth = (cur_mode != `MODE_SLEEP) && (cur_mode != `MODE_STANDBY);
    // FSK adds 1.25 x ramp; OOK omits it  [RQ21] [RQ22]
    wire [31:0] ramp_cyc = ook_mode ? 32'h0 :
        (({24'h0, pa_ramp_time} * `CLK_MHZ * 5) >> 2);
    wire [31:0] tx_delay = `TX_BASE_CYCLES + ramp_cyc +
                           {16'h0, half_bit_cycles};
    always @(posedge mclk)
    begin
        if (rst)
        begin
            state         <= ST_IDLE;
            cur_mode      <= `MODE_SLEEP;
            step_cnt      <= 32'h0;
            regulator_en  <= 1'b0;
            osc_en        <= 1'b0;
            synth_en      <= 1'b0;
            synth_rx_tune <= 1'b0;
            tx_en         <= 1'b0;
            rx_en         <= 1'b0;
            synth_ready   <= 1'b0;
            tx_ready      <= 1'b0;
        end
        else if (mode != cur_mode)
        begin
            // New mode: drop upper blocks and restart ordered wake [RQ19]
            cur_mode    <= mode;
            state       <= ST_OSC;
            step_cnt    <= 32'h0;
            synth_en    <= 1'b0;
            tx_en       <= 1'b0;
            rx_en       <= 1'b0;
            synth_ready <= 1'b0;
            tx_ready    <= 1'b0;
            regulator_en <= (mode != `MODE_SLEEP);               // [RQ17]
            osc_en <= (mode != `MODE_SLEEP);
        end
        else
        begin
            step_cnt <= step_cnt + 32'h1;
            case (state)
                ST_IDLE: ;
                ST_OSC:
                    if (step_cnt >= `WAKE_STEP_CYCLES)
                    begin
                        step_cnt <= 32'h0;
                        state <= want_synth ? ST_SYCAL : ST_RUN;
                        synth_en <= want_synth;                  // [RQ18]
                        synth_rx_tune <= (cur_mode == `MODE_SYNTH_RX) ||
                                         (cur_mode == `MODE_RX);
                    end
                ST_SYCAL:
                    if (step_cnt >= `OSC_CAL_CYCLES)             // [RQ20]
                    begin
                        step_cnt <= 32'h0;
                        synth_ready <= 1'b1;
                        state <= ST_RUN;
                        tx_en <= (cur_mode == `MODE_TX);         // [RQ17]
                        rx_en <= (cur_mode == `MODE_RX);
                    end
                ST_RUN:
                    if (tx_en && step_cnt >= tx_delay)           // [RQ21]
                    begin
                        tx_ready <= 1'b1;
                        state <= ST_IDLE;
                    end
                    else if (!tx_en)
                        state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // rx_ctrl
`default_nettype wire

// File: dv/rx_ctrl_asserts.sv
// Port-level checks for the receive controller
`timescale 1ns/10ps
`default_nettype none
module rx_ctrl_asserts (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [2:0] mode,
    input wire logic       preamble_detector_enable,
    input wire logic       preamble_found_flag,
    input wire logic       timeout_irq,
    input wire logic [7:0] stored_temperature,
    input wire logic       temp_read_valid,
    input wire logic       regulator_en,
    input wire logic       osc_en,
    input wire logic       synth_en,
    input wire logic       synth_rx_tune,
    input wire logic       tx_en,
    input wire logic       rx_en,
    input wire logic       synth_ready,
    input wire logic       tx_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_sleep_all_off: assert property ((mode == 3'h0) [*3] |=>
        !(regulator_en | synth_en | tx_en | rx_en)) else $error("sleep on");
    a_wake_order: assert property ($rose(synth_en) |->
        $past(osc_en, 8) && regulator_en) else $error("synth before osc");
    a_osc_cal_first: assert property ($rose(synth_ready) |->
        $past(synth_en, 60)) else $error("synth ready too soon");
    a_rx_path_only: assert property (rx_en |->
        !tx_en && synth_rx_tune) else $error("rx path wrong");
    a_tx_path_only: assert property (tx_en |->
        synth_en && !synth_rx_tune) else $error("tx path wrong");
    a_found_pulse: assert property (preamble_found_flag |=>
        !preamble_found_flag) else $error("found flag not a pulse");
    a_found_gated: assert property (preamble_found_flag |->
        $past(preamble_detector_enable)) else $error("found while off");
    a_timeout_in_rx: assert property (timeout_irq |->
        $past(mode) == 3'h5) else $error("timeout outside rx");
    a_sleep_hidden: assert property ((mode == 3'h0) [*2] |=>
        !temp_read_valid && stored_temperature == 8'h00)
        else $error("temperature visible in sleep");
    a_tx_startup: assert property ($rose(tx_ready) |->
        $past(tx_en, 1000)) else $error("tx ready too soon");
    // Main traffic kinds are reached
    c_rx_up: cover property ($rose(rx_en));
    c_found: cover property (preamble_found_flag);
    c_timeout: cover property (timeout_irq);
    c_tx_up: cover property ($rose(tx_ready));
endmodule // rx_ctrl_asserts
`default_nettype wire

// File: dv/bit_src.sv
// Demodulator stand-in: bit strobes and a received bit stream
`timescale 1ns/10ps
`default_nettype none
module bit_src (
    input  wire logic mclk,
    input  wire logic alt,        // Alternating pattern when high
    output var  logic bit_strobe,
    output var  logic rx_bit
);
    logic [2:0] cnt = 3'h0;       // Eight clocks per bit
    initial bit_strobe = 1'b0;
    initial rx_bit = 1'b0;
    // Launched on the falling edge so the design samples settled bits
    always @(negedge mclk)
    begin
        cnt <= cnt + 3'h1;
        bit_strobe <= (cnt == 3'h7);
        // Constant ones carry no preamble at all
        if (cnt == 3'h7)
            rx_bit <= alt ? ~rx_bit : 1'b1;
    end
endmodule // bit_src
`default_nettype wire

// File: dv/rx_ctrl_bench.sv
// Self-checking bench for the receive controller
`timescale 1ns/10ps
`default_nettype none
module rx_ctrl_bench;
    logic mclk = 1'b0, rst = 1'b1, alt = 1'b0, ook_mode = 1'b0;
    logic preamble_detector_enable = 1'b1, high_band = 1'b0;
    logic temp_watch_disable = 1'b1, auto_iq_cal_enable = 1'b0;
    logic iq_cal_trigger = 1'b0, sync_match_flag = 1'b0;
    logic [1:0] preamble_size_sel = 2'h0, temp_delta_select = 2'h0;
    logic [4:0] preamble_error_tolerance = 5'h00;
    logic [2:0] mode = 3'h0, rx_trigger_select = 3'h0;
    logic [7:0] pa_ramp_time = 8'h02, temperature = 8'h19;
    logic [7:0] signal_level_value = 8'h10, signal_level_threshold = 8'h40;
    logic [7:0] rssi_wait_limit = 8'h00, preamble_wait_limit = 8'h00;
    logic [7:0] sync_wait_limit = 8'h00, stored_temperature;
    logic [15:0] half_bit_cycles = 16'h0004;   // Eight-clock bit period
    wire  bit_strobe, rx_bit;
    logic preamble_found_flag, timeout_irq, temp_shift_flag, temp_read_valid;
    logic cal_busy, regulator_en, osc_en, synth_en, synth_rx_tune, tx_en;
    logic rx_en, synth_ready, tx_ready;
    wire  [8:0] temp_view = {temp_read_valid, stored_temperature};
    wire  [8:0] band_view = {temp_shift_flag, stored_temperature};
    wire  [4:0] synth_view = {synth_en, synth_ready, tx_en, rx_en,
                              synth_rx_tune};
    int   error_cnt = 0, checked = 0, n, b, i;
    logic [4:0] row [7] = '{5'h10, 5'h12, 5'h08, 5'h06, 5'h07, 5'h18, 5'h10};
    logic [6:0] fire = 7'b1001101;             // Rows expecting a timeout
    always #2 mclk = ~mclk;
    // Short calibration keeps the run brief
    rx_ctrl #(.CAL_CYCLES(100)) dut_u (.mclk, .rst, .bit_strobe, .rx_bit,
        .preamble_detector_enable, .preamble_size_sel, .mode, .ook_mode,
        .preamble_error_tolerance, .pa_ramp_time, .half_bit_cycles,
        .high_band, .temperature, .temp_delta_select, .temp_watch_disable,
        .auto_iq_cal_enable, .iq_cal_trigger, .signal_level_value,
        .signal_level_threshold, .sync_match_flag, .rx_trigger_select,
        .rssi_wait_limit, .preamble_wait_limit, .sync_wait_limit,
        .preamble_found_flag, .timeout_irq, .temp_shift_flag, .cal_busy,
        .stored_temperature, .temp_read_valid, .regulator_en, .osc_en,
        .synth_en, .synth_rx_tune, .tx_en, .rx_en, .synth_ready, .tx_ready);
    bit_src src_u (.mclk, .alt, .bit_strobe, .rx_bit);
    task automatic tick(input int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: pick = rx_en;
            1: pick = preamble_found_flag;
            2: pick = timeout_irq;
            3: pick = cal_busy;
            4: pick = tx_en;
            5: pick = tx_ready;
            default: pick = temp_shift_flag;
        endcase
    endfunction
    // Bounded wait; a required event that never comes ends the run
    task automatic wt(input int k, logic v, int lim, bit must, output int c);
        c = 0;
        while (pick(k) !== v && c < lim)
        begin
            tick(1);
            c++;
        end
        if (must && c >= lim)
        begin
            chk("wait_done", 16'h1, 16'h0);
            give_verdict();
        end
    endtask
    task automatic enter_rx;
        mode = 3'h1;
        tick(100);
        mode = 3'h5;
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        tick(6);
        rst = 1'b0;
        tick(3);
        chk("boot_cal", 16'h1, cal_busy);
        wt(3, 1'b0, 400, 1, n);
        mode = 3'h0;
        tick(4);
        chk("sleep_hide", 16'h0, temp_view);
        iq_cal_trigger = 1'b1;
        tick(1);
        iq_cal_trigger = 1'b0;
        tick(3);
        chk("sleep_trig", 16'h0, cal_busy);
        mode = 3'h1;
        tick(4);
        chk("stby_osc", 16'h5, {regulator_en, synth_en, osc_en});
        chk("stby_temp", 16'h119, temp_view);
        iq_cal_trigger = 1'b1;
        tick(1);
        iq_cal_trigger = 1'b0;
        tick(3);
        chk("user_cal", 16'h1, cal_busy);
        tick(60);
        chk("cal_long", 16'h1, cal_busy);
        wt(3, 1'b0, 200, 1, n);
        for (i = 0; i < 7; i++)
        begin
            preamble_size_sel = (i >= 4) ? 2'h1 : i[1:0];
            preamble_error_tolerance = (i == 4) ? 5'h0a : 5'h00;
            preamble_detector_enable = (i != 6);
            enter_rx();
            wt(0, 1'b1, 200, 1, n);
            // Partner reads alt at this same edge; NBA keeps it ordered
            alt <= (i != 5);
            b = 0;
            while (preamble_found_flag !== 1'b1 && b < 40)
            begin
                tick(1);
                b += (bit_strobe === 1'b1);
            end
            n = (i == 3 || i >= 5) ? 40 : 8 * (preamble_size_sel + 1);
            chk("pre_bits", 16'h1, (b >= n && b <= n + 1));
            alt <= 1'b0;
        end
        preamble_detector_enable = 1'b1;
        for (i = 0; i < 7; i++)
        begin
            rx_trigger_select = (i == 2) ? 3'h6 : (i == 5) ? 3'h0 :
                (i == 6) ? 3'h7 : 3'h1;
            rssi_wait_limit = row[i][4] ? 8'h02 : 8'h00;
            preamble_wait_limit = row[i][3] ? 8'h02 : 8'h00;
            sync_wait_limit = row[i][2] ? 8'h02 : 8'h00;
            signal_level_value = row[i][1] ? 8'h50 : 8'h10;
            sync_match_flag = row[i][0];
            enter_rx();
            wt(2, 1'b1, 500, 0, n);
            b = fire[i] ? (n >= 250 && n <= 360) : (n == 500);
            chk("timeout", 16'h1, b);
        end
        for (i = 0; i < 2; i++)
        begin
            mode = 3'h1;
            ook_mode = (i == 0);
            tick(100);
            mode = 3'h3;
            wt(4, 1'b1, 300, 1, n);
            wt(5, 1'b1, 3000, 1, n);
            b = (i == 0) ? 1254 : 1879;
            chk("tx_delay", 16'h1, n >= b - 2 && n <= b + 2);
        end
        for (i = 0; i < 2; i++)
        begin
            mode = i ? 3'h4 : 3'h2;
            tick(150);
            chk("synth_only", {11'h0, 4'hc, i[0]}, synth_view);
        end
        mode = 3'h1;
        tick(100);
        auto_iq_cal_enable = 1'b1;
        temp_watch_disable = 1'b0;
        temp_delta_select = 2'h1;
        temperature = 8'h20;
        tick(10);
        chk("small_shift", 16'h0, {cal_busy, temp_shift_flag});
        temp_delta_select = 2'h0;
        wt(6, 1'b1, 100, 1, n);
        wt(3, 1'b1, 100, 1, n);
        wt(3, 1'b0, 200, 1, n);
        auto_iq_cal_enable = 1'b0;
        high_band = 1'b1;
        tick(3);
        chk("band_hi", 16'h100, band_view);
        chk("no_auto", 16'h0, cal_busy);
        high_band = 1'b0;
        tick(3);
        chk("band_lo", 16'h020, band_view);
        give_verdict();
    end
endmodule // rx_ctrl_bench
bind rx_ctrl rx_ctrl_asserts chk_u (.mclk, .rst, .mode, .synth_en,
    .preamble_detector_enable, .preamble_found_flag, .timeout_irq,
    .stored_temperature, .temp_read_valid, .regulator_en, .osc_en,
    .synth_rx_tune, .tx_en, .rx_en, .synth_ready, .tx_ready);
`default_nettype wire
